// >>> rtl/fmc_pkg.sv
// Shared constants and types of the feature mode control register bank.
package fmc_pkg;

	// ----------------------------------------
	// Sizes
	// ----------------------------------------
	localparam int DW     = 32;
	localparam int VW     = 12;
	localparam int NF     = 4;
	localparam int ADDR_W = 8;
	localparam int CNT_W  = 8;

	// Field positions are given with bit 0 as the most significant bit.
	function automatic int lsb0(input int msb0);
		return DW - 1 - msb0;
	endfunction

	localparam int POS_PRES    = lsb0(0);
	localparam int POS_ONEPUSH = lsb0(5);
	localparam int POS_ONOFF   = lsb0(6);
	localparam int POS_AUTO    = lsb0(7);
	localparam int POS_VAL_LO  = lsb0(31);

	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [ADDR_W-1:0] FEAT_BASE   = 8'h00;
	localparam logic [ADDR_W-1:0] FEAT_STRIDE = 8'h04;
	localparam logic [ADDR_W-1:0] STATUS_OFF  = 8'h10;

	// Per feature, four bits: [0] off, [1] auto, [2] manual, [3] one-shot.
	localparam logic [4*NF-1:0] FEAT_CAP     = 16'hf_7_b_f;
	localparam logic [NF-1:0]   FEAT_PRESENT = 4'hb;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [VW-1:0] RST_VALUE = 12'h000;
	localparam logic          RST_ONOFF = 1'b0;
	localparam logic          RST_AUTO  = 1'b0;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int ADJ_TIME_NS   = 200;
	localparam logic [CNT_W-1:0] ADJ_CYCLES =
		CNT_W'((ADJ_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [1:0] {
		ST_OFF     = 2'b00,
		ST_AUTO    = 2'b01,
		ST_MANUAL  = 2'b10,
		ST_ONESHOT = 2'b11
	} fmc_state_t;

	typedef struct packed {
		logic one_push;
		logic on_off;
		logic auto_sel;
	} fmc_mode_t;

	typedef struct packed {
		logic              wr;
		logic              rd;
		logic [ADDR_W-1:0] addr;
		logic [DW-1:0]     wdata;
	} fmc_bus_t;

	function automatic fmc_state_t state_of(input fmc_mode_t m);
		if (!m.on_off) begin
			return ST_OFF;
		end else if (m.auto_sel) begin
			return ST_AUTO;
		end else if (m.one_push) begin
			return ST_ONESHOT;
		end
		return ST_MANUAL;
	endfunction

endpackage

// >>> rtl/fmc_ahb_port.sv
// AHB-Lite slave front end: captures the address phase, adds one wait state to reads.
module fmc_ahb_port (
	// Clock and reset
	input  wire logic                         sys_clk,
	input  wire logic                         resetn,
	// AHB-Lite
	input  wire logic                         hsel,
	input  wire logic [31:0]                  haddr,
	input  wire logic [1:0]                   htrans,
	input  wire logic                         hwrite,
	input  wire logic                         hready,
	input  wire logic [31:0]                  hwdata,
	output logic                              hreadyout_q,
	// Register side
	output fmc_pkg::fmc_bus_t                 bus
);

	logic                        act_q;
	logic                        write_q;
	logic [fmc_pkg::ADDR_W-1:0]  addr_q;
	wire                         accept = hsel && hready && htrans[1];

	// Reads wait one cycle because the bank registers its read data before driving hrdata.
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			act_q       <= 1'b0;
			write_q     <= 1'b0;
			addr_q      <= 8'h00;
			hreadyout_q <= 1'b1;
		end else begin
			act_q       <= accept;
			write_q     <= hwrite;
			addr_q      <= haddr[fmc_pkg::ADDR_W-1:0];
			hreadyout_q <= !(accept && !hwrite);
		end
	end

	assign bus.wr    = act_q && write_q;
	assign bus.rd    = act_q && !write_q;
	assign bus.addr  = addr_q;
	assign bus.wdata = hwdata;

endmodule // fmc_ahb_port

// >>> rtl/fmc_adjuster.sv
// Adjustment engine of one feature: a timed run that ends by sampling the target.
module fmc_adjuster (
	// Clock and reset
	input  wire logic                    sys_clk,
	input  wire logic                    resetn,
	// Control
	input  wire logic                    start,
	input  wire logic                    auto_en,
	input  wire logic                    run,
	input  wire logic [fmc_pkg::VW-1:0]  target,
	// Result
	output logic                         busy_q,
	output logic                         done_q,
	output logic [fmc_pkg::VW-1:0]       result_q
);

	logic [fmc_pkg::CNT_W-1:0] cnt_q;
	wire                       go   = (start || auto_en) && !busy_q;
	wire                       last = busy_q && run && cnt_q == 8'h00;

	// A run is dropped without result when run falls, i.e. the feature leaves both auto and one-shot.
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			busy_q   <= 1'b0;
			done_q   <= 1'b0;
			cnt_q    <= 8'h00;
			result_q <= fmc_pkg::RST_VALUE;
		end else begin
			done_q <= last;
			if (go) begin
				busy_q <= 1'b1;
				cnt_q  <= fmc_pkg::ADJ_CYCLES - 8'h01;
			end else if (busy_q && !run) begin
				busy_q <= 1'b0;
			end else if (last) begin
				busy_q   <= 1'b0;
				result_q <= target;
			end else if (busy_q) begin
				cnt_q <= cnt_q - 8'h01;
			end
		end
	end

endmodule // fmc_adjuster

// >>> rtl/fmc_bank.sv
// Feature mode control register bank with AHB-Lite access.
//
// Function
// [R1] Each feature control register is a 32-bit word whose bit 0 is its most significant bit.
// [R2] Every register has on/off, one-shot and auto/manual bits that select one of four states.
// [R3] With on/off at 0 the feature keeps its value and ignores control.
// [R4] With on/off and auto at 1 the block keeps adjusting the feature itself.
// [R5] With on/off at 1 and auto and one-shot at 0 the value comes from software writes.
// [R6] One-shot with on/off 1 and auto 0 adjusts once, clears itself and stays manual.
// [R7] Each feature supports only its own subset of the four states.
// [R8] The value field is valid for control only when the presence flag is one.
// [R9] Software writes to the value take effect only in the manual state.
// [R10] A present feature reads back the value actually in use, adjusted ones included.
// [R11] The one-shot bit reads 1 during the run and clears in the update that loads the value.
//
// Local design decisions: the AHB-Lite register port and the address map.
module fmc_bank (
	// Clock and reset
	input  wire logic                                      sys_clk,
	input  wire logic                                      resetn,
	// AHB-Lite slave
	input  wire logic                                      hsel,
	input  wire logic [31:0]                               haddr,
	input  wire logic [1:0]                                htrans,
	input  wire logic                                      hwrite,
	input  wire logic [2:0]                                hsize,
	input  wire logic [31:0]                               hwdata,
	input  wire logic                                      hready,
	output logic [31:0]                                    hrdata,
	output logic                                           hreadyout,
	output logic                                           hresp,
	// Feature side
	input  wire logic [fmc_pkg::NF-1:0][fmc_pkg::VW-1:0]   adj_target,
	output logic      [fmc_pkg::NF-1:0][fmc_pkg::VW-1:0]   setting,
	output logic      [fmc_pkg::NF-1:0]                    feat_active
);

	// Every check of this bank runs on the one clock and is off while reset is low.
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);

	// ----------------------------------------
	// Bus front end
	// ----------------------------------------
	fmc_pkg::fmc_bus_t bus;
	logic [31:0]       hrdata_q;
	logic              hresp_q;

	fmc_ahb_port u_port (
		.sys_clk     (sys_clk),
		.resetn      (resetn),
		.hsel        (hsel),
		.haddr       (haddr),
		.htrans      (htrans),
		.hwrite      (hwrite),
		.hready      (hready),
		.hwdata      (hwdata),
		.hreadyout_q (hreadyout),
		.bus         (bus)
	);

	// Only word transfers are used, so hsize needs no decode.
	wire unused_size = ^hsize;

	// ----------------------------------------
	// Per-feature state
	// ----------------------------------------
	fmc_pkg::fmc_mode_t               mode_q   [fmc_pkg::NF];
	logic [fmc_pkg::VW-1:0]           val_q    [fmc_pkg::NF];
	logic [fmc_pkg::NF-1:0]           active_q;
	fmc_pkg::fmc_state_t              cur      [fmc_pkg::NF];
	logic [fmc_pkg::NF-1:0]           busy;
	logic [fmc_pkg::NF-1:0]           done;
	logic [fmc_pkg::NF-1:0]           wsel;
	logic [fmc_pkg::NF-1:0]           val_wr;
	logic [fmc_pkg::NF-1:0]           start_os;
	logic [fmc_pkg::VW-1:0]           result   [fmc_pkg::NF];
	logic [31:0]                      word     [fmc_pkg::NF];

	wire fmc_pkg::fmc_mode_t wmode = '{
		one_push: bus.wdata[fmc_pkg::POS_ONEPUSH],
		on_off:   bus.wdata[fmc_pkg::POS_ONOFF],
		auto_sel: bus.wdata[fmc_pkg::POS_AUTO]
	};
	wire fmc_pkg::fmc_state_t req_state = fmc_pkg::state_of(wmode);

	for (genvar i = 0; i < fmc_pkg::NF; i++) begin : g_feat
		localparam logic [fmc_pkg::ADDR_W-1:0] OFF =
			fmc_pkg::ADDR_W'(fmc_pkg::FEAT_BASE + i * fmc_pkg::FEAT_STRIDE);
		localparam logic [3:0] CAP  = fmc_pkg::FEAT_CAP[4*i +: 4];
		localparam logic       PRES = fmc_pkg::FEAT_PRESENT[i];

		wire is_auto    = cur[i] == fmc_pkg::ST_AUTO;
		wire is_oneshot = cur[i] == fmc_pkg::ST_ONESHOT;
		wire run        = PRES && (is_auto || is_oneshot);

		assign cur[i]  = fmc_pkg::state_of(mode_q[i]);                  // see [R2]
		assign wsel[i] = bus.wr && bus.addr == OFF;
		// Unsupported states are refused, and the mode is frozen during a one-shot run.
		// One-shot ends in manual, so it is refused where manual is not supported.
		wire   mode_ok = wsel[i] && CAP[req_state] && !is_oneshot &&     // see [R7]
		                 (req_state != fmc_pkg::ST_ONESHOT || CAP[fmc_pkg::ST_MANUAL]);
		assign val_wr[i]   = wsel[i] && PRES && cur[i] == fmc_pkg::ST_MANUAL; // see [R5] [R9]
		assign start_os[i] = mode_ok && PRES && req_state == fmc_pkg::ST_ONESHOT; // see [R6]
		wire   load_adj    = done[i] && run;                             // see [R4] [R6]

		fmc_adjuster u_adj (
			.sys_clk  (sys_clk),
			.resetn   (resetn),
			.start    (start_os[i]),
			.auto_en  (PRES && is_auto),
			.run      (run),
			.target   (adj_target[i]),
			.busy_q   (busy[i]),
			.done_q   (done[i]),
			.result_q (result[i])
		);

		// The off state simply has no update path, so the value is held.
		always_ff @(posedge sys_clk or negedge resetn) begin
			if (!resetn) begin
				mode_q[i] <= '{one_push: 1'b0, on_off: fmc_pkg::RST_ONOFF,
				               auto_sel: fmc_pkg::RST_AUTO};
				val_q[i]  <= fmc_pkg::RST_VALUE;
			end else begin
				if (mode_ok) begin
					mode_q[i] <= wmode;
				end else if (load_adj) begin
					mode_q[i].one_push <= 1'b0;                              // see [R11]
				end
				if (load_adj) begin
					val_q[i] <= result[i];                                   // see [R10] [R11]
				end else if (val_wr[i]) begin
					val_q[i] <= bus.wdata[fmc_pkg::POS_VAL_LO +: fmc_pkg::VW]; // see [R3] [R9]
				end
			end
		end

		// Absent features read their value as zero and are never active.
		assign word[i] = {PRES, 4'h0, mode_q[i].one_push, mode_q[i].on_off,
		                  mode_q[i].auto_sel, 12'h000,
		                  PRES ? val_q[i] : 12'h000};                     // see [R1] [R8]
		assign setting[i] = val_q[i];

		// ----------------------------------------
		// Checks
		// ----------------------------------------
		legal_state_a: assert property (CAP[cur[i]])                       // see [R7]
			else $error("feature left its supported states");
		off_hold_a: assert property (cur[i] == fmc_pkg::ST_OFF && !mode_ok |=> // see [R3]
			$stable(val_q[i]))
			else $error("value changed while off");
		auto_run_a: assert property (PRES && is_auto && !busy[i] |=>        // see [R4]
			busy[i] || !is_auto)
			else $error("auto state not adjusting");
		manual_wr_a: assert property (val_wr[i] && !load_adj |=>           // see [R5]
			val_q[i] == $past(bus.wdata[fmc_pkg::POS_VAL_LO +: fmc_pkg::VW]))
			else $error("manual write not applied");
		oneshot_end_a: assert property (start_os[i] |=> is_oneshot ##[1:30] // see [R6]
			cur[i] == fmc_pkg::ST_MANUAL)
			else $error("one-shot did not return to manual");
		absent_off_a: assert property (!PRES |-> !active_q[i] &&           // see [R8]
			word[i][11:0] == 12'h000)
			else $error("absent feature shows a value");
		ro_value_a: assert property (wsel[i] && cur[i] != fmc_pkg::ST_MANUAL &&
			!load_adj |=> $stable(val_q[i]))                               // see [R9]
			else $error("value written outside manual");
		push_clear_a: assert property (load_adj && is_oneshot |=>          // see [R11]
			!mode_q[i].one_push && val_q[i] == $past(result[i]))
			else $error("one-shot bit and value not updated together");
		push_busy_a: assert property (bus.rd && bus.addr == OFF && is_oneshot |=> // see [R11]
			hrdata[fmc_pkg::POS_ONEPUSH])
			else $error("one-shot bit low during run");
		oneshot_c: cover property (start_os[i] ##[1:30] load_adj);
		auto_c: cover property (is_auto && load_adj);
	end

	// ----------------------------------------
	// Active flags and read path
	// ----------------------------------------
	logic [31:0] rd_mux;
	logic [fmc_pkg::NF-1:0] hit;
	logic [fmc_pkg::NF-1:0] live;

	always_comb begin
		rd_mux = 32'h0000_0000;
		for (int k = 0; k < fmc_pkg::NF; k++) begin
			hit[k]  = bus.addr == fmc_pkg::ADDR_W'(fmc_pkg::FEAT_BASE +
			          k * fmc_pkg::FEAT_STRIDE);
			live[k] = fmc_pkg::FEAT_PRESENT[k] && mode_q[k].on_off;     // see [R8]
			if (hit[k]) begin
				rd_mux = word[k];
			end
		end
		if (bus.addr == fmc_pkg::STATUS_OFF) begin
			rd_mux = {28'h000_0000, busy};
		end
	end

	// Unmapped reads return zero; every answer is OKAY.
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			hrdata_q <= 32'h0000_0000;
			hresp_q  <= 1'b0;
			active_q <= '0;
		end else begin
			hresp_q  <= 1'b0;
			active_q <= live;
			if (bus.rd) begin
				hrdata_q <= rd_mux;                                       // see [R10]
			end
		end
	end

	assign hrdata      = hrdata_q;
	assign hresp       = hresp_q;
	assign feat_active = active_q;

	read_back_a: assert property (bus.rd && bus.addr == fmc_pkg::FEAT_BASE |=> // see [R1] [R10]
		hrdata[31] == fmc_pkg::FEAT_PRESENT[0] && hrdata[11:0] == $past(val_q[0]))
		else $error("feature 0 read back wrong");
	read_wait_a: assert property (bus.rd |-> !hreadyout ##1 hreadyout)
		else $error("read wait state wrong");
	read_c: cover property (bus.rd ##1 hreadyout);
	write_c: cover property (bus.wr && |val_wr);

endmodule // fmc_bank

// >>> tb/fmc_bank_tb_top.sv
// Self-checking testbench of the feature mode control register bank.
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_fail++; \
	$display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module fmc_bank_tb_top;
	timeunit 1ns;
	timeprecision 1ps;

	localparam int ADJ   = int'(fmc_pkg::ADJ_CYCLES);
	localparam int LIMIT = 5000;

	logic                                    sys_clk;
	logic                                    resetn;
	logic                                    hsel;
	logic [31:0]                             haddr;
	logic [1:0]                              htrans;
	logic                                    hwrite;
	logic [2:0]                              hsize;
	logic [31:0]                             hwdata;
	wire  logic                              hready;
	logic [31:0]                             hrdata;
	logic                                    hreadyout;
	logic                                    hresp;
	logic [fmc_pkg::NF-1:0][fmc_pkg::VW-1:0] adj_target;
	logic [fmc_pkg::NF-1:0][fmc_pkg::VW-1:0] setting;
	logic [fmc_pkg::NF-1:0]                  feat_active;
	int                                      n_fail;
	int                                      checked;
	int                                      cyc;
	logic [31:0]                             d;
	logic [11:0]                             v;
	logic [11:0]                             t;

	// The single slave drives the bus ready line.
	assign hready = hreadyout;

	fmc_bank dut_u (
		.sys_clk(sys_clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .adj_target(adj_target), .setting(setting),
		.feat_active(feat_active)
	);

	// ----------------------------------------
	// Clock, timeout and closing report
	// ----------------------------------------
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	task automatic end_of_test();
		$display("checks %0d failures %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == LIMIT) begin
			n_fail++;
			$display("[FAIL] cycle limit expected below %0d seen %0d", LIMIT, cyc);
			end_of_test();
		end
	end

	// ----------------------------------------
	// Bus tasks and expectation functions
	// ----------------------------------------
	function automatic logic [7:0] fa(input int f);
		return fmc_pkg::FEAT_BASE + fmc_pkg::FEAT_STRIDE * 8'(f);
	endfunction

	function automatic logic [31:0] mw(input logic op, input logic on, input logic au,
		input logic [11:0] val);
		logic [31:0] w;
		w = 32'h0000_0000;
		w[fmc_pkg::POS_ONEPUSH] = op;
		w[fmc_pkg::POS_ONOFF] = on;
		w[fmc_pkg::POS_AUTO] = au;
		w[fmc_pkg::POS_VAL_LO +: fmc_pkg::VW] = val;
		return w;
	endfunction

	// Absent features always show a zero value field.
	function automatic logic [31:0] fw(input int f, input logic op, input logic on,
		input logic au, input logic [11:0] val);
		logic [31:0] w;
		w = mw(op, on, au, fmc_pkg::FEAT_PRESENT[f] ? val : 12'h000);
		w[fmc_pkg::POS_PRES] = fmc_pkg::FEAT_PRESENT[f];
		return w;
	endfunction

	task automatic xfer(input logic [7:0] a, input logic wr, input logic [31:0] wd);
		hsel <= 1'b1;
		haddr <= {24'h00_0000, a};
		hwrite <= wr;
		htrans <= 2'h2;
		do @(posedge sys_clk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge sys_clk); while (hready !== 1'b1);
		d = hrdata;
		`CHK("hresp", 1'b0, hresp)
	endtask

	task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
		xfer(a, 1'b0, 32'h0000_0000);
		`CHK(nm, e, d)
	endtask

	task automatic done(input string nm);
		$display("test %s finished, checks %0d failures %0d", nm, checked, n_fail);
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		resetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0000_0000;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0000_0000;
		adj_target = '0;
		n_fail = 0;
		checked = 0;
		cyc = 0;
		void'($urandom(32'hf426ad88));
		repeat (4) @(posedge sys_clk);
		resetn <= 1'b1;
		@(posedge sys_clk);
		for (int f = 0; f < fmc_pkg::NF; f++) begin
			rd_chk("reset word", fa(f), fw(f, 1'b0, 1'b0, 1'b0, 12'h000));
		end
		rd_chk("unmapped", 8'h20, 32'h0000_0000);
		done("reset");

		adj_target[0] <= 12'($urandom);
		xfer(fa(0), 1'b1, mw(1'b0, 1'b0, 1'b0, 12'h5a5));
		rd_chk("off value", fa(0), fw(0, 1'b0, 1'b0, 1'b0, 12'h000));
		xfer(fa(0), 1'b1, mw(1'b0, 1'b1, 1'b0, 12'h3c3));
		rd_chk("off to manual", fa(0), fw(0, 1'b0, 1'b1, 1'b0, 12'h000));
		`CHK("active f0", 1'b1, feat_active[0])
		for (int i = 0; i < 8; i++) begin
			v = (i == 0) ? 12'hfff : 12'($urandom);
			xfer(fa(0), 1'b1, mw(1'b0, 1'b1, 1'b0, v));
			rd_chk("manual value", fa(0), fw(0, 1'b0, 1'b1, 1'b0, v));
			`CHK("manual setting", v, setting[0])
		end
		done("manual");

		t = 12'($urandom);
		adj_target[0] <= t;
		xfer(fa(0), 1'b1, mw(1'b1, 1'b1, 1'b0, v));
		rd_chk("shot running", fa(0), fw(0, 1'b1, 1'b1, 1'b0, v));
		rd_chk("shot busy", fmc_pkg::STATUS_OFF, 32'h0000_0001);
		repeat (ADJ + 5) @(posedge sys_clk);
		rd_chk("shot result", fa(0), fw(0, 1'b0, 1'b1, 1'b0, t));
		`CHK("shot setting", t, setting[0])
		rd_chk("shot idle", fmc_pkg::STATUS_OFF, 32'h0000_0000);
		xfer(fa(0), 1'b1, mw(1'b0, 1'b1, 1'b0, 12'h001));
		rd_chk("back to manual", fa(0), fw(0, 1'b0, 1'b1, 1'b0, 12'h001));
		done("one shot");

		t = 12'($urandom);
		adj_target[3] <= t;
		xfer(fa(3), 1'b1, mw(1'b0, 1'b1, 1'b1, 12'h000));
		repeat (ADJ + 5) @(posedge sys_clk);
		rd_chk("auto first", fa(3), fw(3, 1'b0, 1'b1, 1'b1, t));
		t = ~t;
		adj_target[3] <= t;
		repeat (2 * ADJ + 5) @(posedge sys_clk);
		rd_chk("auto track", fa(3), fw(3, 1'b0, 1'b1, 1'b1, t));
		`CHK("auto setting", t, setting[3])
		xfer(fa(3), 1'b1, mw(1'b0, 1'b1, 1'b1, 12'h0ff));
		rd_chk("auto ro", fa(3), fw(3, 1'b0, 1'b1, 1'b1, t));
		xfer(fa(3), 1'b1, mw(1'b0, 1'b0, 1'b0, 12'h000));
		adj_target[3] <= ~t;
		repeat (2 * ADJ + 5) @(posedge sys_clk);
		rd_chk("off holds", fa(3), fw(3, 1'b0, 1'b0, 1'b0, t));
		done("auto");

		xfer(fa(1), 1'b1, mw(1'b0, 1'b1, 1'b0, 12'h123));
		rd_chk("no manual f1", fa(1), fw(1, 1'b0, 1'b0, 1'b0, 12'h000));
		xfer(fa(1), 1'b1, mw(1'b1, 1'b1, 1'b0, 12'h000));
		rd_chk("no shot f1", fa(1), fw(1, 1'b0, 1'b0, 1'b0, 12'h000));
		adj_target[2] <= 12'($urandom);
		xfer(fa(2), 1'b1, mw(1'b0, 1'b1, 1'b1, 12'h000));
		repeat (ADJ + 5) @(posedge sys_clk);
		rd_chk("absent f2", fa(2), fw(2, 1'b0, 1'b1, 1'b1, 12'h000));
		`CHK("absent active", 1'b0, feat_active[2])
		xfer(fa(2), 1'b1, mw(1'b1, 1'b1, 1'b0, 12'h000));
		rd_chk("no shot f2", fa(2), fw(2, 1'b0, 1'b1, 1'b1, 12'h000));
		done("subsets");
		end_of_test();
	end

endmodule // fmc_bank_tb_top
